/* File: logic/rvi_pkg.sv */
package rvi_pkg;

  // byte addresses of the registers on the APB bus (one word each)
  localparam logic [7:0] OFS_WORK   = 8'h00;
  localparam logic [7:0] OFS_TMR    = 8'h04;
  localparam logic [7:0] OFS_PCL    = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_FSR    = 8'h10;
  localparam logic [7:0] OFS_PORT_A_LATCH  = 8'h14;
  localparam logic [7:0] OFS_PORT_B_LATCH  = 8'h18;
  localparam logic [7:0] OFS_PROGRAM_COUNTER_UPPER_LATCH = 8'h1C;
  localparam logic [7:0] OFS_INTERRUPT_CONTROL_REG = 8'h20;
  localparam logic [7:0] OFS_PFLAG  = 8'h24;
  localparam logic [7:0] OFS_RESULT = 8'h28;
  localparam logic [7:0] OFS_CCTRL  = 8'h2C;
  localparam logic [7:0] OFS_OPTION = 8'h30;
  localparam logic [7:0] OFS_DIRA   = 8'h34;
  localparam logic [7:0] OFS_DIRB   = 8'h38;
  localparam logic [7:0] OFS_PENA   = 8'h3C;
  localparam logic [7:0] OFS_PWRC   = 8'h40;
  localparam logic [7:0] OFS_CCFG   = 8'h44;
  localparam logic [7:0] OFS_CAUSE  = 8'h48;

  // implemented-bit masks
  localparam logic [7:0] MASK_FULL       = 8'hFF;
  localparam logic [7:0] MASK_PORT_A_LATCH      = 8'h1F;
  localparam logic [7:0] MASK_PROGRAM_COUNTER_UPPER_LATCH     = 8'h1F;
  localparam logic [7:0] MASK_DIRA       = 8'h1F;
  localparam logic [7:0] MASK_PFLAG      = 8'h01;
  localparam logic [7:0] MASK_PENA       = 8'h01;
  localparam logic [7:0] MASK_CCFG       = 8'h03;
  localparam logic [7:0] MASK_CCTRL_PAR  = 8'hFD;
  localparam logic [7:0] MASK_CCTRL_STD  = 8'hDF;
  localparam logic [7:0] MASK_PWRC_PAR   = 8'h07;
  localparam logic [7:0] MASK_PWRC_STD   = 8'h03;

  // reset and wake values
  localparam logic [7:0] PCL_RST     = 8'h00;
  localparam logic [7:0] PC_VECTOR   = 8'h04;
  localparam logic [7:0] PC_STEP     = 8'h01;
  localparam logic [7:0] OPTION_RST  = 8'hFF;
  localparam logic [7:0] DIRA_RST    = 8'h1F;
  localparam logic [7:0] DIRB_RST    = 8'hFF;
  localparam logic [7:0] ZERO_BYTE   = 8'h00;
  localparam logic [2:0] STATUS_HI_RST = 3'h0;
  localparam logic [7:0] PORT_A_LATCH_KEEP  = 8'h10;
  localparam logic [7:0] INTERRUPT_CONTROL_REG_KEEP = 8'h01;

  // field positions
  localparam int ST_TO    = 4;
  localparam int ST_PD    = 3;
  localparam int GIE_BIT  = 7;
  localparam int PWR_PER  = 2;
  localparam int PWR_POR  = 1;
  localparam int PWR_BOR  = 0;
  localparam logic [7:0] STATUS_FLAG_MASK = 8'h18;

  typedef enum logic [1:0] {CAT_NONE, CAT_COLD, CAT_WARM, CAT_WAKE}
    category_t;

  typedef enum logic [3:0] {
    SRC_NONE, SRC_POR, SRC_BOR, SRC_PARITY, SRC_MASTER_CLEAR_PIN_RUN, SRC_MASTER_CLEAR_PIN_SLEEP,
    SRC_WDT_RESET, SRC_WDT_WAKE, SRC_INT_WAKE
  } source_t;

  typedef struct packed {
    logic [7:0] work;
    logic [7:0] tmr;
    logic [7:0] program_counter_low;
    logic [7:0] status;
    logic [7:0] indirect_pointer;
    logic [7:0] port_a_latch;
    logic [7:0] port_b_latch;
    logic [7:0] program_counter_upper_latch;
    logic [7:0] interrupt_control_reg;
    logic [7:0] pflag;
    logic [7:0] result;
    logic [7:0] cctrl;
    logic [7:0] option;
    logic [7:0] dira;
    logic [7:0] dirb;
    logic [7:0] pena;
    logic [7:0] pwrc;
    logic [7:0] ccfg;
    logic [1:0] cause;
    logic [31:0] rdata;
  } state_t;

  function automatic category_t category_of(input source_t s);
    case (s)
      SRC_POR, SRC_BOR, SRC_PARITY:                 category_of = CAT_COLD;
      SRC_MASTER_CLEAR_PIN_RUN, SRC_MASTER_CLEAR_PIN_SLEEP, SRC_WDT_RESET:  category_of = CAT_WARM;
      SRC_WDT_WAKE, SRC_INT_WAKE:                   category_of = CAT_WAKE;
      default:                                      category_of = CAT_NONE;
    endcase
  endfunction

endpackage

/* File: logic/reset_source_decode.sv */
`timescale 1ns/1ps
module reset_source_decode
  import rvi_pkg::*;
(
  input  wire logic    por,
  input  wire logic    bor,
  input  wire logic    parity_err,
  input  wire logic    parity_variant,
  input  wire logic    master_clear_pin,
  input  wire logic    wdt,
  input  wire logic    sleeping,
  input  wire logic    int_wake,
  output source_t      source
);

  // cold before warm before wake
  always_comb begin
    if (por) begin
      source = SRC_POR;
    end else if (bor) begin
      source = SRC_BOR;
    end else if (parity_err && parity_variant) begin
      source = SRC_PARITY;
    end else if (master_clear_pin) begin
      source = sleeping ? SRC_MASTER_CLEAR_PIN_SLEEP : SRC_MASTER_CLEAR_PIN_RUN;
    end else if (wdt) begin
      source = sleeping ? SRC_WDT_WAKE : SRC_WDT_RESET;
    end else if (int_wake && sleeping) begin
      source = SRC_INT_WAKE;
    end else begin
      source = SRC_NONE;
    end
  end

endmodule

/* File: logic/reset_value_init.sv */
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module reset_value_init
  import rvi_pkg::*;
#(
  parameter bit PARITY_VARIANT = 1'b1
) (
  input  wire logic        MCLK,
  input  wire logic        SYS_RST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        POR_EVT,
  input  wire logic        BOR_EVT,
  input  wire logic        PARITY_ERR_EVT,
  input  wire logic        MASTER_CLEAR_PIN_EVT,
  input  wire logic        WDT_TIMEOUT,
  input  wire logic        IN_SLEEP,
  input  wire logic        INT_WAKE,
  input  wire logic [2:0]  WAKE_INTERRUPT_CONTROL_REG_FLAGS,
  input  wire logic        WAKE_PERIPH_FLAG,
  output logic      [7:0]  PC_LOW,
  output logic      [7:0]  STATUS_BITS,
  output logic      [7:0]  INTERRUPT_CONTROL_REG_BITS,
  output logic      [4:0]  PORT_A_DIR,
  output logic      [7:0]  PORT_B_DIR,
  output logic      [1:0]  RESET_CATEGORY
);

  localparam logic [7:0] MASK_CCTRL =
    PARITY_VARIANT ? MASK_CCTRL_PAR : MASK_CCTRL_STD;
  localparam logic [7:0] MASK_PWRC =
    PARITY_VARIANT ? MASK_PWRC_PAR : MASK_PWRC_STD;
  localparam logic [7:0] PWRC_PWRUP =
    PARITY_VARIANT ? 8'h04 : 8'h00;

  state_t    st_reg;
  state_t    st_next;
  source_t   src;
  category_t cat;

  reset_source_decode u_decode (
    .por            (POR_EVT),
    .bor            (BOR_EVT),
    .parity_err     (PARITY_ERR_EVT),
    .parity_variant (PARITY_VARIANT),
    .master_clear_pin           (MASTER_CLEAR_PIN_EVT),
    .wdt            (WDT_TIMEOUT),
    .sleeping       (IN_SLEEP),
    .int_wake       (INT_WAKE),
    .source         (src)
  );

  assign cat = category_of(src);

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a[1:0] == 2'h0) && (a <= OFS_CAUSE);
  endfunction

  // read value of a register; masks keep unimplemented bits at zero
  function automatic logic [31:0] read_word(input state_t s,
                                            input logic [7:0] a);
    logic [7:0] v;
    v = ZERO_BYTE;
    case (a)
      OFS_WORK:   v = s.work;
      OFS_TMR:    v = s.tmr;
      OFS_PCL:    v = s.program_counter_low;
      OFS_STATUS: v = s.status;
      OFS_FSR:    v = s.indirect_pointer;
      OFS_PORT_A_LATCH:  v = s.port_a_latch & MASK_PORT_A_LATCH;
      OFS_PORT_B_LATCH:  v = s.port_b_latch;
      OFS_PROGRAM_COUNTER_UPPER_LATCH: v = s.program_counter_upper_latch & MASK_PROGRAM_COUNTER_UPPER_LATCH;
      OFS_INTERRUPT_CONTROL_REG: v = s.interrupt_control_reg;
      OFS_PFLAG:  v = s.pflag & MASK_PFLAG;
      OFS_RESULT: v = s.result;
      OFS_CCTRL:  v = s.cctrl & MASK_CCTRL;
      OFS_OPTION: v = s.option;
      OFS_DIRA:   v = s.dira & MASK_DIRA;
      OFS_DIRB:   v = s.dirb;
      OFS_PENA:   v = s.pena & MASK_PENA;
      OFS_PWRC:   v = s.pwrc & MASK_PWRC;
      OFS_CCFG:   v = s.ccfg & MASK_CCFG;
      OFS_CAUSE:  v = {6'h00, s.cause};
      default:    v = ZERO_BYTE;
    endcase
    read_word = {24'h000000, v};
  endfunction

  always_comb begin
    st_next = st_reg;
    // read data captured in the setup phase
    if (PSEL && !PENABLE) begin
      st_next.rdata = read_word(st_reg, PADDR);
    end
    // software writes; a reset event below overrides them
    if (PSEL && PENABLE && PWRITE) begin
      case (PADDR)
        OFS_WORK:   st_next.work   = PWDATA[7:0];
        OFS_TMR:    st_next.tmr    = PWDATA[7:0];
        OFS_PCL:    st_next.program_counter_low    = PWDATA[7:0];
        OFS_STATUS: st_next.status = (PWDATA[7:0] & ~STATUS_FLAG_MASK) |
                                     (st_reg.status & STATUS_FLAG_MASK);
        OFS_FSR:    st_next.indirect_pointer    = PWDATA[7:0];
        OFS_PORT_A_LATCH:  st_next.port_a_latch  = PWDATA[7:0] & MASK_PORT_A_LATCH;
        OFS_PORT_B_LATCH:  st_next.port_b_latch  = PWDATA[7:0];
        OFS_PROGRAM_COUNTER_UPPER_LATCH: st_next.program_counter_upper_latch = PWDATA[7:0] & MASK_PROGRAM_COUNTER_UPPER_LATCH;
        OFS_INTERRUPT_CONTROL_REG: st_next.interrupt_control_reg = PWDATA[7:0];
        OFS_PFLAG:  st_next.pflag  = PWDATA[7:0] & MASK_PFLAG;
        OFS_RESULT: st_next.result = PWDATA[7:0];
        OFS_CCTRL:  st_next.cctrl  = PWDATA[7:0] & MASK_CCTRL;
        OFS_OPTION: st_next.option = PWDATA[7:0];
        OFS_DIRA:   st_next.dira   = PWDATA[7:0] & MASK_DIRA;
        OFS_DIRB:   st_next.dirb   = PWDATA[7:0];
        OFS_PENA:   st_next.pena   = PWDATA[7:0] & MASK_PENA;
        OFS_PWRC:   st_next.pwrc   = PWDATA[7:0] & MASK_PWRC;
        OFS_CCFG:   st_next.ccfg   = PWDATA[7:0] & MASK_CCFG;
        default:    st_next.program_counter_low    = st_next.program_counter_low;
      endcase
    end
    if (cat != CAT_NONE) begin
      st_next.cause = cat;
    end
    // work, timer, pointer, port b and result are never touched here
    if (cat == CAT_COLD || cat == CAT_WARM) begin
      st_next.program_counter_low    = PCL_RST;
      st_next.program_counter_upper_latch = ZERO_BYTE;
      st_next.option = OPTION_RST;
      st_next.dira   = DIRA_RST;
      st_next.dirb   = DIRB_RST;
      st_next.interrupt_control_reg = st_reg.interrupt_control_reg & INTERRUPT_CONTROL_REG_KEEP;
      st_next.port_a_latch  = st_reg.port_a_latch & PORT_A_LATCH_KEEP;
      st_next.cctrl  = ZERO_BYTE;
      st_next.ccfg   = ZERO_BYTE;
      st_next.pena   = ZERO_BYTE;
      st_next.pflag  = ZERO_BYTE;
      st_next.status[7:5] = STATUS_HI_RST;
    end
    case (src)
      SRC_POR, SRC_BOR, SRC_PARITY: begin
        st_next.status[ST_TO] = 1'b1;
        st_next.status[ST_PD] = 1'b1;
      end
      SRC_MASTER_CLEAR_PIN_SLEEP: begin
        st_next.status[ST_TO] = 1'b1;
        st_next.status[ST_PD] = 1'b0;
      end
      SRC_WDT_RESET: begin
        st_next.status[ST_TO] = 1'b0;
        st_next.status[ST_PD] = 1'b1;
      end
      SRC_WDT_WAKE: begin
        st_next.status[ST_TO] = 1'b0;
        st_next.status[ST_PD] = 1'b0;
      end
      SRC_INT_WAKE: begin
        st_next.status[ST_TO] = 1'b1;
        st_next.status[ST_PD] = 1'b0;
      end
      default: st_next.status = st_next.status;
    endcase
    if (cat == CAT_WAKE) begin
      if (src == SRC_INT_WAKE && st_reg.interrupt_control_reg[GIE_BIT]) begin
        st_next.program_counter_low = PC_VECTOR;
      end else begin
        st_next.program_counter_low = st_reg.program_counter_low + PC_STEP;
      end
      st_next.interrupt_control_reg[2:0] = st_next.interrupt_control_reg[2:0] | WAKE_INTERRUPT_CONTROL_REG_FLAGS;
      st_next.pflag[0]    = st_next.pflag[0] | WAKE_PERIPH_FLAG;
    end
    // power-control flags
    if (PARITY_VARIANT) begin
      case (src)
        SRC_POR: begin
          st_next.pwrc[PWR_PER] = 1'b1;
          st_next.pwrc[PWR_POR] = 1'b0;
        end
        SRC_BOR:    st_next.pwrc[PWR_BOR] = 1'b0;
        SRC_PARITY: st_next.pwrc[PWR_PER] = 1'b0;
        SRC_MASTER_CLEAR_PIN_RUN, SRC_MASTER_CLEAR_PIN_SLEEP, SRC_WDT_RESET,
        SRC_WDT_WAKE, SRC_INT_WAKE:
          st_next.pwrc[PWR_PER] = 1'b1;
        default: st_next.pwrc = st_next.pwrc;
      endcase
    end else begin
      case (src)
        SRC_POR: st_next.pwrc[PWR_POR] = 1'b0;
        SRC_BOR: st_next.pwrc[PWR_BOR] = 1'b0;
        default: st_next.pwrc = st_next.pwrc;
      endcase
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      st_reg        <= '0;
      st_reg.status <= 8'h18;
      st_reg.option <= OPTION_RST;
      st_reg.dira   <= DIRA_RST;
      st_reg.dirb   <= DIRB_RST;
      st_reg.pwrc   <= PWRC_PWRUP;
      st_reg.cause  <= CAT_COLD;
    end else begin
      st_reg <= st_next;
    end
  end

  assign PRDATA         = st_reg.rdata;
  assign PREADY         = PSEL && PENABLE;
  assign PSLVERR        = PSEL && PENABLE && !addr_hit(PADDR);
  assign PC_LOW         = st_reg.program_counter_low;
  assign STATUS_BITS    = st_reg.status;
  assign INTERRUPT_CONTROL_REG_BITS    = st_reg.interrupt_control_reg;
  assign PORT_A_DIR     = st_reg.dira[4:0];
  assign PORT_B_DIR     = st_reg.dirb;
  assign RESET_CATEGORY = st_reg.cause;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  logic reset_any;
  assign reset_any = (cat == CAT_COLD) || (cat == CAT_WARM);

  chk_vector_load: assert property (
    (src == SRC_INT_WAKE && st_reg.interrupt_control_reg[GIE_BIT]) |=> PC_LOW == 8'h04)
    else $error("vector not loaded on interrupt wake");
  chk_pc_step: assert property (
    (src == SRC_WDT_WAKE) |=> PC_LOW == $past(PC_LOW) + 8'h01)
    else $error("pc low did not step on wake");
  chk_pc_clear: assert property (
    reset_any |=> PC_LOW == 8'h00 && st_reg.program_counter_upper_latch == 8'h00)
    else $error("pc not cleared by reset");
  chk_unimpl_zero: assert property (
    st_reg.port_a_latch[7:5] == 3'h0 && st_reg.dira[7:5] == 3'h0 &&
    st_reg.ccfg[7:2] == 6'h00 && (st_reg.cctrl & ~MASK_CCTRL) == 8'h00)
    else $error("unimplemented bit set");
  chk_wake_flags: assert property (
    (cat == CAT_WAKE) |=> (INTERRUPT_CONTROL_REG_BITS[2:0] & $past(WAKE_INTERRUPT_CONTROL_REG_FLAGS))
                          == $past(WAKE_INTERRUPT_CONTROL_REG_FLAGS))
    else $error("wake cause flag missing");
  chk_status_cold: assert property (
    (cat == CAT_COLD) |=> STATUS_BITS[7:3] == 5'h03)
    else $error("status wrong after cold reset");
  chk_status_wake: assert property (
    (cat == CAT_WAKE) |=> STATUS_BITS[7:5] == $past(STATUS_BITS[7:5]) &&
                          STATUS_BITS[2:0] == $past(STATUS_BITS[2:0]))
    else $error("status kept bits changed on wake");
  chk_dir_inputs: assert property (
    reset_any |=> PORT_A_DIR == 5'h1F && PORT_B_DIR == 8'hFF &&
                  st_reg.option == 8'hFF)
    else $error("direction or option not all ones");
  chk_gie_clear: assert property (
    reset_any |=> INTERRUPT_CONTROL_REG_BITS[7:1] == 7'h00 &&
                  INTERRUPT_CONTROL_REG_BITS[0] == $past(INTERRUPT_CONTROL_REG_BITS[0]))
    else $error("interrupt control wrong after reset");
  chk_per_force: assert property (
    (PARITY_VARIANT && (cat == CAT_WARM || cat == CAT_WAKE))
      |=> st_reg.pwrc[PWR_PER])
    else $error("parity flag not forced");
  chk_per_clear: assert property (
    (src == SRC_PARITY) |=> !st_reg.pwrc[PWR_PER] && PC_LOW == 8'h00)
    else $error("parity reset did not clear flag");

  chk_port_a_latch_reset: assert property (
    reset_any |=> st_reg.port_a_latch[3:0] == 4'h0 &&
                  st_reg.port_a_latch[4] == $past(st_reg.port_a_latch[4]))
    else $error("port a latch wrong after reset");
  chk_conv_clear: assert property (
    reset_any |=> st_reg.cctrl == 8'h00 && st_reg.ccfg == 8'h00 &&
                  st_reg.pena == 8'h00)
    else $error("converter or enable not cleared");
  chk_wake_keep: assert property (
    (cat == CAT_WAKE && !(PSEL && PENABLE && PWRITE))
      |=> PORT_A_DIR == $past(PORT_A_DIR) &&
          PORT_B_DIR == $past(PORT_B_DIR) &&
          st_reg.option == $past(st_reg.option) &&
          st_reg.program_counter_upper_latch == $past(st_reg.program_counter_upper_latch))
    else $error("kept register changed on wake");
  chk_poweron_flag: assert property (
    (src == SRC_POR) |=> !st_reg.pwrc[PWR_POR])
    else $error("power-on flag not cleared");

  cov_cold: cover property (cat == CAT_COLD);
  cov_warm: cover property (src == SRC_WDT_RESET);
  cov_vector: cover property (src == SRC_INT_WAKE && st_reg.interrupt_control_reg[GIE_BIT]);
  cov_read: cover property (PSEL && PENABLE && !PWRITE);
  cov_wdt_wake: cover property (src == SRC_WDT_WAKE);

endmodule

/* File: dv/reset_value_init_tb.sv */
`timescale 1ns/1ps
module reset_value_init_tb
  import rvi_pkg::*;
;
  logic        MCLK, SYS_RST, PSEL, PENABLE, PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic        PREADY, PSLVERR;
  logic        POR_EVT, BOR_EVT, PARITY_ERR_EVT, MASTER_CLEAR_PIN_EVT, WDT_TIMEOUT;
  logic        IN_SLEEP, INT_WAKE, WAKE_PERIPH_FLAG;
  logic [2:0]  WAKE_INTERRUPT_CONTROL_REG_FLAGS;
  logic [7:0]  PC_LOW, STATUS_BITS, INTERRUPT_CONTROL_REG_BITS, PORT_B_DIR;
  logic [4:0]  PORT_A_DIR;
  logic [1:0]  RESET_CATEGORY;
  logic [7:0]  m [0:18];
  logic [7:0]  s_addr [0:1];
  logic [7:0]  cc_std, pw_std;
  logic [31:0] PRDATA_STD, q_std;
  int          n_mismatch, comparisons;

  reset_value_init dut_u (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .POR_EVT(POR_EVT),
    .BOR_EVT(BOR_EVT), .PARITY_ERR_EVT(PARITY_ERR_EVT),
    .MASTER_CLEAR_PIN_EVT(MASTER_CLEAR_PIN_EVT), .WDT_TIMEOUT(WDT_TIMEOUT), .IN_SLEEP(IN_SLEEP),
    .INT_WAKE(INT_WAKE), .WAKE_INTERRUPT_CONTROL_REG_FLAGS(WAKE_INTERRUPT_CONTROL_REG_FLAGS),
    .WAKE_PERIPH_FLAG(WAKE_PERIPH_FLAG), .PC_LOW(PC_LOW),
    .STATUS_BITS(STATUS_BITS), .INTERRUPT_CONTROL_REG_BITS(INTERRUPT_CONTROL_REG_BITS),
    .PORT_A_DIR(PORT_A_DIR), .PORT_B_DIR(PORT_B_DIR),
    .RESET_CATEGORY(RESET_CATEGORY));

  reset_value_init #(.PARITY_VARIANT(1'b0)) dut_std_u (
    .MCLK(MCLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA_STD),
    .PREADY(), .PSLVERR(), .POR_EVT(POR_EVT),
    .BOR_EVT(BOR_EVT), .PARITY_ERR_EVT(PARITY_ERR_EVT),
    .MASTER_CLEAR_PIN_EVT(MASTER_CLEAR_PIN_EVT), .WDT_TIMEOUT(WDT_TIMEOUT), .IN_SLEEP(IN_SLEEP),
    .INT_WAKE(INT_WAKE), .WAKE_INTERRUPT_CONTROL_REG_FLAGS(WAKE_INTERRUPT_CONTROL_REG_FLAGS),
    .WAKE_PERIPH_FLAG(WAKE_PERIPH_FLAG), .PC_LOW(), .STATUS_BITS(),
    .INTERRUPT_CONTROL_REG_BITS(), .PORT_A_DIR(), .PORT_B_DIR(), .RESET_CATEGORY());

  initial MCLK = 1'b0;
  always #50 MCLK = ~MCLK;

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string msg);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: %s seen %h expected %h",
               $time, msg, seen, exp);
    end
  endtask

  // readable bits of each word index
  function automatic logic [7:0] rmask(input int i);
    case (i)
      5, 7, 13: rmask = MASK_PORT_A_LATCH;
      9, 15:    rmask = MASK_PFLAG;
      11:       rmask = MASK_CCTRL_PAR;
      16:       rmask = MASK_PWRC_PAR;
      17, 18:   rmask = MASK_CCFG;
      default:  rmask = MASK_FULL;
    endcase
  endfunction

  // status timeout/power-down bits and category are not writable
  function automatic logic [7:0] wmask(input int i);
    wmask = (i == 3) ? ~STATUS_FLAG_MASK : (i == 18) ? 8'h00 : rmask(i);
  endfunction

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic err);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1'b1;
    @(posedge MCLK);
    while (PREADY !== 1'b1 && n < 50) begin
      @(posedge MCLK);
      n++;
    end
    chk(32'(PREADY), 32'h1, "ready in access phase");
    q = PRDATA;
    q_std = PRDATA_STD;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask

  task automatic wr_reg(input int i, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, 8'(i * 4), {$urandom} & 32'hFFFF_FF00 | 32'(d), q, e);
    m[i] = (m[i] & ~wmask(i)) | (d & wmask(i));
    if (i == 11) cc_std = d & MASK_CCTRL_STD;
    if (i == 16) pw_std = d & MASK_PWRC_STD;
  endtask

  task automatic read_all();
    logic [31:0] q;
    logic        e;
    for (int i = 0; i < 19; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0, q, e);
      chk(q, {24'h0, m[i]}, "register readback");
      chk(32'(e), 32'h0, "slave error on mapped read");
      if (i == 11) chk(q_std, {24'h0, cc_std}, "std converter ctrl");
      if (i == 16) chk(q_std, {24'h0, pw_std}, "std power flags");
    end
    chk(32'(PC_LOW), 32'(m[2]), "pc low port");
    chk(32'(STATUS_BITS), 32'(m[3]), "status port");
    chk(32'(INTERRUPT_CONTROL_REG_BITS), 32'(m[8]), "interrupt_control_reg port");
    chk(32'(PORT_A_DIR), 32'(m[13][4:0]), "dir a port");
    chk(32'(PORT_B_DIR), 32'(m[14]), "dir b port");
    chk(32'(RESET_CATEGORY), 32'(m[18][1:0]), "category port");
  endtask

  task automatic model_ev(input int s, input logic [2:0] f, input logic pf);
    logic [7:0] st;
    st = m[3];
    if (s <= 5) begin
      m[2] = 8'h00;
      m[5] &= 8'h10;
      m[7] = 8'h00;
      m[8] &= 8'h01;
      m[9] = 8'h00;
      m[11] = 8'h00;
      m[12] = 8'hFF;
      m[13] = 8'h1F;
      m[14] = 8'hFF;
      m[15] = 8'h00;
      m[17] = 8'h00;
    end
    // standard variant ignores the parity cause
    if (s <= 5 && s != 2) cc_std = 8'h00;
    case (s)
      0: begin
        m[3] = 8'h18 | (st & 8'h07);
        m[16] = (m[16] & 8'h01) | 8'h04;
        m[18] = 8'h01;
        pw_std &= 8'hFD;
      end
      1: begin
        m[3] = 8'h18 | (st & 8'h07);
        m[16] &= 8'hFE;
        m[18] = 8'h01;
        pw_std &= 8'hFE;
      end
      2: begin
        m[3] = 8'h18 | (st & 8'h07);
        m[16] &= 8'hFB;
        m[18] = 8'h01;
      end
      3: m[3] = st & 8'h1F;
      4: m[3] = (st & 8'h07) | 8'h10;
      5: m[3] = (st & 8'h07) | 8'h08;
      6: m[3] = st & 8'hE7;
      7: m[3] = (st & 8'hE7) | 8'h10;
      default: ;
    endcase
    if (s >= 3 && s <= 5) begin
      m[16] |= 8'h04;
      m[18] = 8'h02;
    end
    if (s == 6 || s == 7) begin
      m[2] = (s == 7 && m[8][GIE_BIT]) ? PC_VECTOR : m[2] + PC_STEP;
      m[8] |= {5'h0, f};
      m[9] |= {7'h0, pf};
      m[16] |= 8'h04;
      m[18] = 8'h03;
    end
  endtask

  // 0 por 1 bor 2 parity 3 master_clear_pin 4 master_clear_pin asleep 5 wdt 6 wdt asleep
  // 7 int wake 8 int request while awake (ignored)
  task automatic cause(input int s);
    logic [2:0] f;
    logic       pf;
    f = 3'($urandom);
    pf = 1'($urandom);
    POR_EVT <= (s == 0);
    BOR_EVT <= (s == 1);
    PARITY_ERR_EVT <= (s == 2);
    MASTER_CLEAR_PIN_EVT <= (s == 3 || s == 4);
    WDT_TIMEOUT <= (s == 5 || s == 6);
    IN_SLEEP <= (s == 4 || s == 6 || s == 7);
    INT_WAKE <= (s == 7 || s == 8);
    WAKE_INTERRUPT_CONTROL_REG_FLAGS <= f;
    WAKE_PERIPH_FLAG <= pf;
    @(posedge MCLK);
    {POR_EVT, BOR_EVT, PARITY_ERR_EVT, MASTER_CLEAR_PIN_EVT} <= 4'h0;
    {WDT_TIMEOUT, IN_SLEEP, INT_WAKE, WAKE_PERIPH_FLAG} <= 4'h0;
    WAKE_INTERRUPT_CONTROL_REG_FLAGS <= 3'h0;
    @(posedge MCLK);
    model_ev(s, f, pf);
  endtask

  task automatic sys_reset(input int cycles);
    SYS_RST <= 1'b1;
    repeat (cycles) @(posedge MCLK);
    SYS_RST <= 1'b0;
    @(posedge MCLK);
    foreach (m[i]) m[i] = 8'h00;
    m[3] = 8'h18; m[12] = 8'hFF; m[13] = 8'h1F; m[14] = 8'hFF;
    m[16] = 8'h04; m[18] = 8'h01;
    cc_std = 8'h00;
    pw_std = 8'h00;
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    final_report();
  end

  initial begin
    logic [31:0] q;
    logic        e;
    int          s;
    SYS_RST = 1'b1;
    {PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {POR_EVT, BOR_EVT, PARITY_ERR_EVT, MASTER_CLEAR_PIN_EVT, WDT_TIMEOUT} = '0;
    {IN_SLEEP, INT_WAKE, WAKE_INTERRUPT_CONTROL_REG_FLAGS, WAKE_PERIPH_FLAG} = '0;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(32'h525d));
    @(posedge MCLK);
    sys_reset(11);
    read_all();
    $display("test reset values done");
    apb(1'b1, 8'h4C, 32'hFFFF_FFFF, q, e);
    chk(32'(e), 32'h1, "unmapped write error");
    foreach (s_addr[k]) begin
      apb(1'b0, s_addr[k], 32'h0, q, e);
      chk(32'(e), 32'h1, "unmapped read error");
      chk(q, 32'h0, "unmapped read data");
    end
    read_all();
    $display("test unmapped access done");
    for (int r = 0; r < 27; r++) begin
      s = (r < 9) ? r : int'($urandom_range(8, 0));
      for (int i = 0; i < 19; i++) wr_reg(i, 8'($urandom));
      if (s == 7 && r < 9) wr_reg(8, 8'h80 | 8'($urandom));
      cause(s);
      read_all();
      $display("test round %0d cause %0d done", r, s);
    end
    for (int i = 0; i < 19; i++) wr_reg(i, 8'($urandom));
    sys_reset(1);
    read_all();
    $display("test second reset done");
    final_report();
  end

  initial begin
    s_addr[0] = 8'h4C;
    s_addr[1] = 8'h4A;
  end
endmodule
